/* hdl/core_sfr_pkg.sv */
// constants and types for the low special function register bank
`default_nettype none
package core_sfr_pkg;
	// register addresses
	localparam logic [7:0] ADDR_PORT0 = 8'h80;
	localparam logic [7:0] ADDR_SP = 8'h81;
	localparam logic [7:0] ADDR_DP0L = 8'h82;
	localparam logic [7:0] ADDR_DP0H = 8'h83;
	localparam logic [7:0] ADDR_DP1L = 8'h84;
	localparam logic [7:0] ADDR_DP1H = 8'h85;
	localparam logic [7:0] ADDR_PSEL = 8'h86;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
	localparam logic [7:0] ADDR_T0L = 8'h8a;
	localparam logic [7:0] ADDR_T1L = 8'h8b;
	localparam logic [7:0] ADDR_T0H = 8'h8c;
	localparam logic [7:0] ADDR_T1H = 8'h8d;
	localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;
	// reset values and read answers
	localparam logic [7:0] RST_PORT0 = 8'hff;
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CLOCK_CONTROL = 8'h01;
	localparam logic [7:0] RD_UNMAPPED = 8'hff;
	localparam logic [7:0] PSEL_MASK = 8'h01;
	localparam logic [7:0] POWER_CONTROL_MASK = 8'hcf;
	// timing
	localparam logic [3:0] PRESC_LAST = 4'hb;
	localparam logic [1:0] MC_LAST = 2'h3;
	localparam logic [5:0] CLKS_PER_MC = 6'h04;
	localparam logic [5:0] XM_BASE_MC = 6'h02;
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [26:0] WD_RST_EXTRA = 27'h0000200;
	localparam logic [4:0] WD_EXP0 = 5'h11;
	localparam logic [4:0] WD_EXP_STEP = 5'h03;
	typedef struct packed {
		logic timer1_overflow, timer1_run, timer0_overflow, timer0_run;
		logic ext_int1_flag, ext_int1_type, ext_int0_flag, ext_int0_type;
	} timer_control_t;
	typedef struct packed {
		logic pin_qualified_run, counter_select, timer_mode_hi_sel, timer_mode_lo_sel;
	} timer_mode_half_t;
	typedef struct packed {
		timer_mode_half_t t1;
		timer_mode_half_t t0;
	} timer_mode_t;
	typedef struct packed {
		logic baud_doubler, framing_detect_enable;
		logic [1:0] unused;
		logic user_flag1, user_flag0, power_down_request, cpu_sleep_request;
	} power_control_t;
	typedef struct packed {
		logic [1:0] watchdog_period_sel;
		logic timer2_prescale_sel, timer1_prescale_sel, timer0_prescale_sel;
		logic [2:0] stretch_sel;
	} clock_control_t;
	typedef enum logic {XM_IDLE = 1'b0, XM_BUSY = 1'b1} xm_state_t;
endpackage : core_sfr_pkg
`default_nettype wire

/* hdl/core_sfr_timer_pointer_bank.sv */
// low special function register bank with timers 0 and 1 and pointers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - pointer select bit 0 picks pointer pair one, else pair zero.
// - pointer select bits 7 to 1 always read zero.
// - stack pointer holds scratchpad address of stack top.
// - baud doubler doubles serial baud rate in modes 1, 2, 3.
// - framing detect enable turns serial bit 7 into the framing error flag.
// - two user flags are plain read/write storage.
// - power down request stops every clock and freezes execution.
// - sleep request stops only the cpu clock; peripherals keep running.
// - overflow flag set by overflow, cleared on vectoring, software writable.
// - run bit switches its timer on or off.
// - ext flag set on edge or level, cleared on vectoring in edge mode.
// - type bit selects falling edge or low level trigger.
// - pin qualified run also needs the interrupt pin high to count.
// - counter select counts count pin falling edges instead of clock.
// - mode 0 is 8-bit counter behind 5-bit prescaler in low byte.
// - mode 1 cascades both bytes into a 16-bit counter.
// - mode 2 reloads the low byte from the high byte on overflow.
// - mode 3 splits timer 0; timer 1 stops.
// - watchdog select gives 2^17..2^26 clocks; reset time-out 512 more.
// - prescale select bit picks clock divided by 4, else by 12.
// - stretch field makes an external move last stretch plus 2 cycles.
// - an on-chip data move always lasts 2 machine cycles.
// - framing error flag set on bad stop bit, held until software clears.
module core_sfr_timer_pointer_bank (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic t0_count_pin,
	input wire logic t1_count_pin,
	input wire logic ext_int0_pin_n,
	input wire logic ext_int1_pin_n,
	input wire logic timer0_vec,
	input wire logic timer1_vec,
	input wire logic ext_int0_vec,
	input wire logic ext_int1_vec,
	input wire logic wake,
	input wire logic fe_event,
	input wire logic fe_clear,
	input wire logic xdata_start,
	input wire logic xdata_onchip,
	output logic xdata_busy,
	output logic [7:0] port0_oe_n,
	output logic [15:0] active_data_pointer,
	output logic [7:0] stack_pointer,
	output logic baud_doubler,
	output logic framing_detect_enable,
	output logic framing_error_flag,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic timer2_tick,
	output logic [26:0] wdt_int_cycles,
	output logic [26:0] wdt_rst_cycles,
	output logic timer0_overflow,
	output logic timer1_overflow,
	output logic ext_int0_flag,
	output logic ext_int1_flag
);
	// one count step: {overflow, high, low}
	function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] hi,
		input logic [7:0] lo);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0] s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		s8 = {1'b0, lo} + 9'h001;
		case (m)
			core_sfr_pkg::MODE_13BIT: step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			core_sfr_pkg::MODE_16BIT: step = s16;
			core_sfr_pkg::MODE_RELOAD: step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
			default: step = {s8[8], hi, s8[7:0]};
		endcase
	endfunction : step

	logic [7:0] port0, dp0l, dp0h, dp1l, dp1h, psel, t0l, t0h, t1l, t1h;
	core_sfr_pkg::power_control_t power_control;
	core_sfr_pkg::timer_control_t timer_control;
	core_sfr_pkg::timer_mode_t timer_mode;
	core_sfr_pkg::clock_control_t clock_control;
	logic [3:0] presc;
	logic tick4, tick12, tick_t0, tick_t1;
	logic [3:0] sync1, sync2, sync3;
	logic t0_fall, t1_fall, x0_fall, x1_fall, int0_high, int1_high;
	logic run0, run1, run0h, cnt0, cnt1, cnt0h;
	logic [16:0] s0, s1;
	logic [8:0] s0h;
	logic wr_any;
	core_sfr_pkg::xm_state_t xm_state;
	logic [5:0] xm_left;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	assign wr_any = sfr_wr;

	// general storage registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			port0 <= core_sfr_pkg::RST_PORT0;
			stack_pointer <= core_sfr_pkg::RST_SP;
			dp0l <= core_sfr_pkg::RST_ZERO;
			dp0h <= core_sfr_pkg::RST_ZERO;
			dp1l <= core_sfr_pkg::RST_ZERO;
			dp1h <= core_sfr_pkg::RST_ZERO;
			psel <= core_sfr_pkg::RST_ZERO;
			timer_mode <= core_sfr_pkg::RST_ZERO;
			clock_control <= core_sfr_pkg::RST_CLOCK_CONTROL;
		end
		else if (sfr_wr)
		begin
			if (sfr_addr == core_sfr_pkg::ADDR_PORT0)
				port0 <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_SP)
				stack_pointer <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP0L)
				dp0l <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP0H)
				dp0h <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP1L)
				dp1l <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP1H)
				dp1h <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_PSEL)
				psel <= sfr_wdata & core_sfr_pkg::PSEL_MASK;
			else if (sfr_addr == core_sfr_pkg::ADDR_TIMER_MODE)
				timer_mode <= sfr_wdata;
			else if (sfr_addr == core_sfr_pkg::ADDR_CLOCK_CONTROL)
				clock_control <= sfr_wdata;
		end
	end

	// power control; a wake event ends sleep and power down
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			power_control <= core_sfr_pkg::RST_ZERO;
		else if (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_POWER_CONTROL)
			power_control <= sfr_wdata & core_sfr_pkg::POWER_CONTROL_MASK;
		else if (wake)
		begin
			power_control.power_down_request <= 1'b0;
			power_control.cpu_sleep_request <= 1'b0;
		end
	end

	// framing error flag; a bad stop bit beats a clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			framing_error_flag <= 1'b0;
		else if (fe_event && power_control.framing_detect_enable)
			framing_error_flag <= 1'b1;
		else if (fe_clear)
			framing_error_flag <= 1'b0;
	end

	// ----------------------------------------
	// pin synchronisers and prescaler
	// ----------------------------------------
	// two flops, then a third stage for edge detection
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1 <= 4'hf;
			sync2 <= 4'hf;
			sync3 <= 4'hf;
		end
		else
		begin
			sync1 <= {ext_int1_pin_n, ext_int0_pin_n, t1_count_pin, t0_count_pin};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	assign t0_fall = sync3[0] & ~sync2[0];
	assign t1_fall = sync3[1] & ~sync2[1];
	assign x0_fall = sync3[2] & ~sync2[2];
	assign x1_fall = sync3[3] & ~sync2[3];
	assign int0_high = sync2[2];
	assign int1_high = sync2[3];

	// divide by 12 counter; every fourth clock is a machine cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst || presc == core_sfr_pkg::PRESC_LAST)
			presc <= 4'h0;
		else
			presc <= presc + 4'h1;
	end
	assign tick4 = presc[1:0] == core_sfr_pkg::MC_LAST;
	assign tick12 = presc == core_sfr_pkg::PRESC_LAST;
	assign tick_t0 = clock_control.timer0_prescale_sel ? tick4 : tick12;
	assign tick_t1 = clock_control.timer1_prescale_sel ? tick4 : tick12;
	assign timer2_tick = periph_clk_en & (clock_control.timer2_prescale_sel ? tick4 : tick12);

	// ----------------------------------------
	// timers 0 and 1
	// ----------------------------------------
	assign run0 = timer_control.timer0_run & (~timer_mode.t0.pin_qualified_run | int0_high);
	assign run1 = timer_control.timer1_run & (~timer_mode.t1.pin_qualified_run | int1_high);
	assign cnt0 = periph_clk_en & run0 & (timer_mode.t0.counter_select ? t0_fall : tick_t0);
	assign cnt1 = periph_clk_en & run1 & (timer_mode.t1.counter_select ? t1_fall : tick_t1)
		& ({timer_mode.t1.timer_mode_hi_sel, timer_mode.t1.timer_mode_lo_sel} != core_sfr_pkg::MODE_SPLIT);
	assign cnt0h = periph_clk_en & timer_control.timer1_run & tick_t0
		& ({timer_mode.t0.timer_mode_hi_sel, timer_mode.t0.timer_mode_lo_sel} == core_sfr_pkg::MODE_SPLIT);
	assign run0h = cnt0h;
	assign s0 = step({timer_mode.t0.timer_mode_hi_sel, timer_mode.t0.timer_mode_lo_sel}, t0h, t0l);
	assign s1 = step({timer_mode.t1.timer_mode_hi_sel, timer_mode.t1.timer_mode_lo_sel}, t1h, t1l);
	assign s0h = {1'b0, t0h} + 9'h001;

	// count bytes; a software write wins over a count in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			t0l <= core_sfr_pkg::RST_ZERO;
			t0h <= core_sfr_pkg::RST_ZERO;
			t1l <= core_sfr_pkg::RST_ZERO;
			t1h <= core_sfr_pkg::RST_ZERO;
		end
		else
		begin
			if (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_T0L)
				t0l <= sfr_wdata;
			else if (cnt0)
				t0l <= s0[7:0];
			if (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_T0H)
				t0h <= sfr_wdata;
			else if (run0h)
				t0h <= s0h[7:0];
			else if (cnt0)
				t0h <= s0[15:8];
			if (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_T1L)
				t1l <= sfr_wdata;
			else if (cnt1)
				t1l <= s1[7:0];
			if (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_T1H)
				t1h <= sfr_wdata;
			else if (cnt1)
				t1h <= s1[15:8];
		end
	end

	// timer control flags; hardware set wins over any clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			timer_control <= core_sfr_pkg::RST_ZERO;
		else
		begin
			if (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_TIMER_CONTROL)
				timer_control <= sfr_wdata;
			else
			begin
				if (timer0_vec)
					timer_control.timer0_overflow <= 1'b0;
				if (timer1_vec)
					timer_control.timer1_overflow <= 1'b0;
				if (ext_int0_vec && timer_control.ext_int0_type)
					timer_control.ext_int0_flag <= 1'b0;
				if (ext_int1_vec && timer_control.ext_int1_type)
					timer_control.ext_int1_flag <= 1'b0;
			end
			if (cnt0 && s0[16])
				timer_control.timer0_overflow <= 1'b1;
			if ((cnt1 && s1[16]) || (run0h && s0h[8]))
				timer_control.timer1_overflow <= 1'b1;
			if (!timer_control.ext_int0_type)
				timer_control.ext_int0_flag <= ~int0_high;
			else if (x0_fall)
				timer_control.ext_int0_flag <= 1'b1;
			if (!timer_control.ext_int1_type)
				timer_control.ext_int1_flag <= ~int1_high;
			else if (x1_fall)
				timer_control.ext_int1_flag <= 1'b1;
		end
	end

	// ----------------------------------------
	// external data move timing
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			xm_state <= core_sfr_pkg::XM_IDLE;
			xm_left <= 6'h00;
		end
		else
			case (xm_state)
				core_sfr_pkg::XM_IDLE:
					if (xdata_start)
					begin
						xm_state <= core_sfr_pkg::XM_BUSY;
						xm_left <= xdata_onchip ? 6'(core_sfr_pkg::XM_BASE_MC * core_sfr_pkg::CLKS_PER_MC)
							: 6'((core_sfr_pkg::XM_BASE_MC + 6'(clock_control.stretch_sel)) * core_sfr_pkg::CLKS_PER_MC);
					end
				default:
				begin
					xm_left <= xm_left - 6'h01;
					if (xm_left == 6'h01)
						xm_state <= core_sfr_pkg::XM_IDLE;
				end
			endcase
	end
	assign xdata_busy = xm_state == core_sfr_pkg::XM_BUSY;

	// ----------------------------------------
	// read path and outputs
	// ----------------------------------------
	assign sfr_hit = sfr_addr >= core_sfr_pkg::ADDR_PORT0 && sfr_addr <= core_sfr_pkg::ADDR_CLOCK_CONTROL;

	// read data captured one cycle after a read strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sfr_rdata <= core_sfr_pkg::RST_ZERO;
		else if (sfr_rd)
		begin
			if (sfr_addr == core_sfr_pkg::ADDR_PORT0)
				sfr_rdata <= port0;
			else if (sfr_addr == core_sfr_pkg::ADDR_SP)
				sfr_rdata <= stack_pointer;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP0L)
				sfr_rdata <= dp0l;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP0H)
				sfr_rdata <= dp0h;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP1L)
				sfr_rdata <= dp1l;
			else if (sfr_addr == core_sfr_pkg::ADDR_DP1H)
				sfr_rdata <= dp1h;
			else if (sfr_addr == core_sfr_pkg::ADDR_PSEL)
				sfr_rdata <= psel & core_sfr_pkg::PSEL_MASK;
			else if (sfr_addr == core_sfr_pkg::ADDR_POWER_CONTROL)
				sfr_rdata <= power_control;
			else if (sfr_addr == core_sfr_pkg::ADDR_TIMER_CONTROL)
				sfr_rdata <= timer_control;
			else if (sfr_addr == core_sfr_pkg::ADDR_TIMER_MODE)
				sfr_rdata <= timer_mode;
			else if (sfr_addr == core_sfr_pkg::ADDR_T0L)
				sfr_rdata <= t0l;
			else if (sfr_addr == core_sfr_pkg::ADDR_T1L)
				sfr_rdata <= t1l;
			else if (sfr_addr == core_sfr_pkg::ADDR_T0H)
				sfr_rdata <= t0h;
			else if (sfr_addr == core_sfr_pkg::ADDR_T1H)
				sfr_rdata <= t1h;
			else if (sfr_addr == core_sfr_pkg::ADDR_CLOCK_CONTROL)
				sfr_rdata <= clock_control;
			else
				sfr_rdata <= core_sfr_pkg::RD_UNMAPPED;
		end
	end

	assign active_data_pointer = psel[0] ? {dp1h, dp1l} : {dp0h, dp0l};
	assign port0_oe_n = port0; // open drain: drive low where the latch holds 0
	assign baud_doubler = power_control.baud_doubler;
	assign framing_detect_enable = power_control.framing_detect_enable;
	assign cpu_clk_en = ~(power_control.power_down_request | power_control.cpu_sleep_request);
	assign periph_clk_en = ~power_control.power_down_request;
	assign wdt_int_cycles = 27'h0000001 << (core_sfr_pkg::WD_EXP0
		+ 5'(clock_control.watchdog_period_sel * core_sfr_pkg::WD_EXP_STEP));
	assign wdt_rst_cycles = wdt_int_cycles + core_sfr_pkg::WD_RST_EXTRA;
	assign timer0_overflow = timer_control.timer0_overflow;
	assign timer1_overflow = timer_control.timer1_overflow;
	assign ext_int0_flag = timer_control.ext_int0_flag;
	assign ext_int1_flag = timer_control.ext_int1_flag;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_onchip_move;
		xdata_busy [*8] ##1 !xdata_busy;
	endsequence
	property p_psel_reads_zero;
		@(posedge clk) disable iff (sys_rst)
		sfr_rd && sfr_addr == core_sfr_pkg::ADDR_PSEL |=> sfr_rdata[7:1] == 7'h00;
	endproperty
	a_psel_reads_zero: assert property (p_psel_reads_zero)
		else $error("select reserved bits set");
	property p_pointer_pick;
		@(posedge clk) disable iff (sys_rst)
		sfr_wr && sfr_addr == core_sfr_pkg::ADDR_PSEL
			|=> active_data_pointer == ($past(sfr_wdata[0]) ? {dp1h, dp1l} : {dp0h, dp0l});
	endproperty
	a_pointer_pick: assert property (p_pointer_pick) else $error("wrong active pointer");
	property p_t0_overflow;
		@(posedge clk) disable iff (sys_rst)
		cnt0 && s0[16] |=> timer0_overflow;
	endproperty
	a_t0_overflow: assert property (p_t0_overflow) else $error("overflow flag not set");
	property p_level_follows;
		@(posedge clk) disable iff (sys_rst)
		!timer_control.ext_int0_type && !wr_any |=> ext_int0_flag == !$past(int0_high);
	endproperty
	a_level_follows: assert property (p_level_follows)
		else $error("level flag not following pin");
	property p_stopped_timer;
		@(posedge clk) disable iff (sys_rst)
		!timer_control.timer0_run && !wr_any |=> $stable(t0l);
	endproperty
	a_stopped_timer: assert property (p_stopped_timer) else $error("stopped timer moved");
	property p_gate_holds;
		@(posedge clk) disable iff (sys_rst)
		timer_mode.t0.pin_qualified_run && !int0_high && !wr_any |=> $stable(t0l);
	endproperty
	a_gate_holds: assert property (p_gate_holds) else $error("gated timer counted");
	property p_power_down;
		@(posedge clk) disable iff (sys_rst)
		sfr_wr && sfr_addr == core_sfr_pkg::ADDR_POWER_CONTROL && sfr_wdata[1] |=> !periph_clk_en && !cpu_clk_en;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power down left clocks on");
	property p_sleep;
		@(posedge clk) disable iff (sys_rst)
		power_control.cpu_sleep_request && !power_control.power_down_request |-> !cpu_clk_en && periph_clk_en;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep clock gating wrong");
	property p_onchip_move;
		@(posedge clk) disable iff (sys_rst)
		xdata_start && xdata_onchip && !xdata_busy |=> s_onchip_move;
	endproperty
	a_onchip_move: assert property (p_onchip_move) else $error("on-chip move length wrong");
endmodule : core_sfr_timer_pointer_bank
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the low register bank with timers and pointers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, t0_count_pin = 1'b1, t1_count_pin = 1'b1;
	logic ext_int0_pin_n = 1'b1, ext_int1_pin_n = 1'b1, timer0_vec = 1'b0, timer1_vec = 1'b0;
	logic ext_int0_vec = 1'b0, ext_int1_vec = 1'b0, wake = 1'b0, fe_event = 1'b0;
	logic fe_clear = 1'b0, xdata_start = 1'b0, xdata_onchip = 1'b0;
	logic [7:0] sfr_rdata, port0_oe_n, stack_pointer;
	logic [15:0] active_data_pointer;
	logic [26:0] wdt_int_cycles, wdt_rst_cycles;
	logic sfr_hit, xdata_busy, baud_doubler, framing_detect_enable, framing_error_flag;
	logic cpu_clk_en, periph_clk_en, timer2_tick, timer0_overflow, timer1_overflow;
	logic ext_int0_flag, ext_int1_flag;
	logic [7:0] model [0:15];
	int failures = 0;
	int cmp_count = 0;

	// ----------------------------------------
	// clock and device
	// ----------------------------------------
	always #5 clk = ~clk;

	core_sfr_timer_pointer_bank u_dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .t0_count_pin(t0_count_pin), .t1_count_pin(t1_count_pin),
		.ext_int0_pin_n(ext_int0_pin_n), .ext_int1_pin_n(ext_int1_pin_n),
		.timer0_vec(timer0_vec), .timer1_vec(timer1_vec), .ext_int0_vec(ext_int0_vec),
		.ext_int1_vec(ext_int1_vec), .wake(wake), .fe_event(fe_event), .fe_clear(fe_clear),
		.xdata_start(xdata_start), .xdata_onchip(xdata_onchip), .xdata_busy(xdata_busy),
		.port0_oe_n(port0_oe_n), .active_data_pointer(active_data_pointer),
		.stack_pointer(stack_pointer), .baud_doubler(baud_doubler),
		.framing_detect_enable(framing_detect_enable), .framing_error_flag(framing_error_flag),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .timer2_tick(timer2_tick),
		.wdt_int_cycles(wdt_int_cycles), .wdt_rst_cycles(wdt_rst_cycles),
		.timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
		.ext_int0_flag(ext_int0_flag), .ext_int1_flag(ext_int1_flag));

	// ----------------------------------------
	// helpers and reference model
	// ----------------------------------------
	// picks a watched output by index
	function automatic logic sig(input int i);
		case (i)
			0: sig = timer0_overflow;
			1: sig = timer1_overflow;
			2: sig = ext_int0_flag;
			3: sig = ext_int1_flag;
			5: sig = xdata_busy;
			default: sig = timer2_tick;
		endcase
	endfunction : sig

	// counts to overflow for a preset count in a given mode
	function automatic int model_ticks(input int mode, input int th, input int tl);
		case (mode)
			0: model_ticks = 32'h2000 - (th * 32 + tl % 32);
			1: model_ticks = 32'h10000 - (th * 256 + tl);
			2: model_ticks = 256 - tl;
			default: model_ticks = 256 - th;
		endcase
	endfunction : model_ticks

	task automatic end_sim;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// bounded wait for a watched output to reach a level, counting falling edges
	task automatic wait_for(input int i, input logic lvl, input int max, output int n);
		n = 0;
		while (sig(i) !== lvl && n < max)
		begin
			@(negedge clk);
			n++;
		end
		if (sig(i) !== lvl)
		begin
			failures++;
			$display("unexpected wait bound on output %0d", i);
			end_sim();
		end
	endtask : wait_for

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask : rd

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse

	task automatic set_pin(input int i, input logic v);
		@(negedge clk);
		if (i == 1)
			ext_int1_pin_n = v;
		else
			ext_int0_pin_n = v;
	endtask : set_pin

	// preset timer 0, start it and time the overflow against the model
	task automatic ovf(input int mode, input int th, input int tl, input int ck,
		input logic [7:0] run, input int idx);
		int n;
		int p;
		int c;
		p = ck[3] ? 4 : 12;
		c = model_ticks(mode, th, tl) * p;
		wr(8'h88, 8'h00);
		wr(8'h89, mode[7:0]);
		wr(8'h8c, th[7:0]);
		wr(8'h8a, tl[7:0]);
		wr(8'h8e, ck[7:0]);
		wr(8'h88, run);
		wait_for(idx, 1'b1, c + 20, n);
		check("overflow_window", 32'(n >= c - p - 2 && n <= c + 2), 32'd1);
	endtask : ovf

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int n;
		int i;
		int k;
		logic [7:0] d;
		logic [7:0] v;
		void'($urandom(32'h8e75dc87));
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		// reset values, unmapped read and address decode
		for (i = 0; i < 16; i++)
		begin
			rd(8'h80 + i[7:0], d);
			v = (i == 0) ? core_sfr_pkg::RST_PORT0 : (i == 1) ? core_sfr_pkg::RST_SP :
				(i == 14) ? core_sfr_pkg::RST_CLOCK_CONTROL : (i == 15) ? core_sfr_pkg::RD_UNMAPPED : 8'h00;
			check("reset_read", {24'h0, d}, {24'h0, v});
			check("sfr_hit", {31'h0, sfr_hit}, {31'h0, i != 15});
		end
		// random register traffic against the model, skipping timer control
		for (k = 0; k < 3; k++)
		begin
			for (i = 0; i < 15; i++)
			begin
				v = 8'($urandom()) & ((i == 7) ? 8'hfc : 8'hff);
				if (i == 9)
					v = v & 8'h88;
				if (i != 8)
					wr(8'h80 + i[7:0], v);
				model[i] = v & ((i == 6) ? 8'h01 : (i == 7) ? 8'hcf : 8'hff);
			end
			for (i = 0; i < 15; i++)
			begin
				rd(8'h80 + i[7:0], d);
				if (i != 8)
					check("reg_read", {24'h0, d}, {24'h0, model[i]});
			end
			check("active_ptr", {16'h0, active_data_pointer},
				{16'h0, model[6][0] ? {model[5], model[4]} : {model[3], model[2]}});
			check("stack_ptr", {24'h0, stack_pointer}, {24'h0, model[1]});
			check("port0", {24'h0, port0_oe_n}, {24'h0, model[0]});
			check("baud_dbl", {31'h0, baud_doubler}, {31'h0, model[7][7]});
			check("fe_en", {31'h0, framing_detect_enable}, {31'h0, model[7][6]});
		end
		// watchdog period decode
		for (k = 0; k < 4; k++)
		begin
			wr(8'h8e, {k[1:0], 6'h01});
			check("wdt_int", {5'h0, wdt_int_cycles}, 32'd1 << (17 + 3 * k));
			check("wdt_rst", {5'h0, wdt_rst_cycles}, (32'd1 << (17 + 3 * k)) + 512);
		end
		// timer 2 tick period for both prescale choices
		for (k = 0; k < 2; k++)
		begin
			wr(8'h8e, {2'h0, k[0], 5'h01});
			wait_for(4, 1'b1, 30, n);
			@(negedge clk);
			wait_for(4, 1'b1, 30, n);
			check("t2_period", n + 1, k ? 4 : 12);
		end
		// external move length, every stretch then on-chip
		for (k = 0; k < 9; k++)
		begin
			wr(8'h8e, (k < 8) ? k[7:0] : 8'h07);
			@(negedge clk);
			xdata_start = 1'b1;
			xdata_onchip = (k == 8);
			@(negedge clk);
			xdata_start = 1'b0;
			wait_for(5, 1'b0, 100, n);
			check("xdata_len", n, (k < 8) ? (k + 2) * 4 : 8);
		end
		// timer modes 1, 0 and 3, then mode 2 reload with vectoring
		ovf(1, 8'hfe, 8'hff, 8'h08, 8'h10, 0);
		ovf(0, 8'hfe, 8'h1f, 8'h00, 8'h10, 0);
		ovf(8'h33, 8'hf0, 8'h00, 8'h08, 8'h40, 1);
		rd(8'h8b, d);
		check("t1_stopped", {24'h0, d}, {24'h0, model[11]});
		ovf(2, 8'hf0, 8'hf0, 8'h08, 8'h10, 0);
		pulse(timer0_vec);
		check("vec_clear", {31'h0, timer0_overflow}, 32'd0);
		wait_for(0, 1'b1, 200, n);
		check("reload_period", n + 2, 16 * 4);
		// gated run holds while the interrupt pin is low
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h0a);
		ext_int0_pin_n = 1'b0;
		wr(8'h88, 8'h10);
		n = 0;
		repeat (150) @(negedge clk) n += timer0_overflow;
		check("gated_hold", n, 0);
		ext_int0_pin_n = 1'b1;
		wait_for(0, 1'b1, 300, n);
		check("gated_run", {31'h0, timer0_overflow}, 32'd1);
		// counting falling edges of the count pin
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h06);
		wr(8'h8a, 8'hfd);
		wr(8'h88, 8'h10);
		for (k = 0; k < model_ticks(2, 8'hfd, 8'hfd); k++)
		begin
			check("count_early", {31'h0, timer0_overflow}, 32'd0);
			t0_count_pin = 1'b0;
			repeat (4) @(negedge clk);
			t0_count_pin = 1'b1;
			repeat (4) @(negedge clk);
		end
		check("count_ovf", {31'h0, timer0_overflow}, 32'd1);
		// external interrupt flags in edge and level mode
		for (i = 0; i < 2; i++)
		begin
			wr(8'h88, i ? 8'h04 : 8'h01);
			set_pin(i, 1'b0);
			wait_for(2 + i, 1'b1, 8, n);
			set_pin(i, 1'b1);
			repeat (4) @(negedge clk);
			check("edge_hold", {31'h0, sig(2 + i)}, 32'd1);
			if (i == 1)
				pulse(ext_int1_vec);
			else
				pulse(ext_int0_vec);
			check("edge_vec", {31'h0, sig(2 + i)}, 32'd0);
			wr(8'h88, 8'h00);
			set_pin(i, 1'b0);
			wait_for(2 + i, 1'b1, 8, n);
			if (i == 1)
				pulse(ext_int1_vec);
			else
				pulse(ext_int0_vec);
			check("level_vec", {31'h0, sig(2 + i)}, 32'd1);
			set_pin(i, 1'b1);
			wait_for(2 + i, 1'b0, 8, n);
		end
		// framing error flag is sticky until cleared
		wr(8'h87, 8'h40);
		pulse(fe_event);
		repeat (3) @(negedge clk);
		check("fe_set", {31'h0, framing_error_flag}, 32'd1);
		pulse(fe_clear);
		check("fe_clr", {31'h0, framing_error_flag}, 32'd0);
		// sleep and power down clock gating, each left by wake
		for (k = 1; k < 3; k++)
		begin
			wr(8'h87, k[7:0]);
			check("cpu_clk", {31'h0, cpu_clk_en}, 32'd0);
			check("periph_clk", {31'h0, periph_clk_en}, k == 1);
			pulse(wake);
			check("wake_clk", {30'h0, cpu_clk_en, periph_clk_en}, 32'd3);
		end
		end_sim();
	end

	// cuts a hung run short
	initial
	begin
		repeat (100000) @(posedge clk);
		failures++;
		$display("unexpected run length limit reached");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
